// File: simd_fp_datapath_model.sv
`timescale 1ns/1ps

module simd_fp_datapath_model (
   // Operation from the pipeline
   input  wire logic [0:0]   op_valid_i,
   input  wire logic [127:0] src1_i,
   input  wire logic [127:0] src2_i,
   input  wire logic [19:0]  flag_req_i,
   // Datapath answer
   output logic      [127:0] dp_result_o,
   output logic      [19:0]  dp_flags_o,
   output logic      [2:0]   dp_cmp_flags_o
);
   // Off-cycle outputs are scrambled so a stale sample cannot pass as a result
   always_comb begin
      dp_result_o    = op_valid_i ? (src1_i ^ src2_i) : ~(src1_i ^ src2_i);
      dp_flags_o     = op_valid_i ? flag_req_i : ~flag_req_i;
      dp_cmp_flags_o = op_valid_i ? 3'h2 : 3'h5;
   end
endmodule

// File: simd_fp_exc_pkg.sv
package simd_fp_exc_pkg;

   // Register offsets (byte addresses)
   localparam logic [7:0] CSR_OFFSET     = 8'h00;
   localparam logic [7:0] OS_CTRL_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET  = 8'h08;

   // Vector control/status fields
   localparam int NUM_CLASSES    = 6;
   localparam int FLAG_LSB       = 0;
   localparam int INVALID_OP_BIT = 0;
   localparam int UNDERFLOW_BIT  = 4;
   localparam int DAZ_BIT        = 6;
   localparam int MASK_LSB       = 7;
   localparam int RC_LSB         = 13;
   localparam int FTZ_BIT        = 15;
   localparam int CSR_WIDTH      = 16;
   localparam logic [15:0] CSR_RESET = 16'h1f80;

   // Control register four
   localparam int OS_FAULT_BIT     = 10;
   localparam logic OS_CTRL_RESET  = 1'b0;

   // Fault status register
   localparam int STAT_VEC_FAULT_BIT = 8;
   localparam int STAT_BAD_OP_BIT    = 9;

   // Classifier result fields
   localparam int CL_SGN  = 0;
   localparam int CL_ZERO = 1;
   localparam int CL_INF  = 2;
   localparam int CL_SNAN = 3;
   localparam int CL_NAN  = 4;

   // Special values
   localparam logic [31:0] DEFAULT_NAN_SP = 32'hffc0_0000;
   localparam logic [63:0] DEFAULT_NAN_DP = 64'hfff8_0000_0000_0000;
   localparam logic [31:0] INT_INDEFINITE = 32'h8000_0000;
   localparam logic [63:0] QUIET_BIT_SP   = 64'h0000_0000_0040_0000;
   localparam logic [63:0] QUIET_BIT_DP   = 64'h0008_0000_0000_0000;
   localparam logic [7:0]  CVT_SP_EXP_LIMIT = 8'h9e;
   localparam logic [10:0] CVT_DP_EXP_LIMIT = 11'h41e;
   localparam logic [2:0]  UNORDERED_FLAGS  = 3'h7;

   typedef enum logic [3:0] {
      OP_INT         = 4'h0,
      OP_ADD         = 4'h1,
      OP_SUB         = 4'h2,
      OP_ADDSUB      = 4'h3,
      OP_MUL         = 4'h4,
      OP_DIV         = 4'h5,
      OP_SQRT        = 4'h6,
      OP_MAX         = 4'h7,
      OP_MIN         = 4'h8,
      OP_CMP_MASK    = 4'h9,
      OP_CMP_ORD     = 4'ha,
      OP_CMP_UNORD   = 4'hb,
      OP_CVT_FP      = 4'hc,
      OP_CVT_INT     = 4'hd,
      OP_CVT_INT_TR  = 4'he,
      OP_STACK_TRUNC = 4'hf
   } op_e;

   typedef enum logic [2:0] {
      PRED_EQ    = 3'h0,
      PRED_LT    = 3'h1,
      PRED_LE    = 3'h2,
      PRED_UNORD = 3'h3,
      PRED_NEQ   = 3'h4,
      PRED_NLT   = 3'h5,
      PRED_NLE   = 3'h6,
      PRED_ORD   = 3'h7
   } cmp_pred_e;

endpackage

// File: simd_fp_exc_sva.sv
`timescale 1ns/1ps

module simd_fp_exc_sva
   import simd_fp_exc_pkg::*;
(
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Register bus
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic       wb_ack_o,
   // Operation side
   input wire logic       op_valid_i,
   input wire logic [3:0] op_code_i,
   input wire logic       done_o,
   input wire logic       result_we_o,
   input wire logic       vector_fp_fault_o,
   input wire logic       invalid_opcode_fault_o,
   input wire logic       daz_mode_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   done_follow_a: assert property (op_valid_i |=> done_o)
      else $error("completion missing one cycle after an operation");
   done_spur_a: assert property (!op_valid_i |=> !done_o)
      else $error("completion without an operation");
   int_quiet_a: assert property (op_valid_i && op_code_i == OP_INT |=>
      !vector_fp_fault_o && !invalid_opcode_fault_o) else $error("integer op faulted");
   stack_quiet_a: assert property (op_valid_i && op_code_i == OP_STACK_TRUNC |=>
      !(vector_fp_fault_o || invalid_opcode_fault_o || result_we_o))
      else $error("stack store touched vector state");
   fault_one_a: assert property (!(vector_fp_fault_o && invalid_opcode_fault_o))
      else $error("both fault kinds raised");
   fault_keep_a: assert property (vector_fp_fault_o || invalid_opcode_fault_o |->
      done_o && !result_we_o) else $error("fault with destination write");
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   daz_write_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_sel_i[0] && wb_adr_i == CSR_OFFSET |=> daz_mode_o == $past(wb_dat_i[DAZ_BIT]))
      else $error("denormal zero mode not taken from write");

   cover property (vector_fp_fault_o);
   cover property (invalid_opcode_fault_o);
   cover property (wb_ack_o && !wb_we_i);
endmodule

bind simd_fp_exception_unit simd_fp_exc_sva i_simd_fp_exc_sva (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i), .op_code_i(op_code_i), .done_o(done_o),
   .result_we_o(result_we_o), .vector_fp_fault_o(vector_fp_fault_o),
   .invalid_opcode_fault_o(invalid_opcode_fault_o), .daz_mode_o(daz_mode_o));

// File: simd_fp_exception_unit.sv
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Packed integer operations never raise numeric exceptions
// - Six classes, each with flag and mask
// - Exceptions reported when faulting instruction completes
// - Masks and flags loaded, stored via registers
// - Unmasked with OS support gives vector fault
// - Without OS support raise invalid-opcode fault instead
// - Invalid flag bit 0, invalid mask bit 7
// - Masked invalid result overwrites destination register
// - Arithmetic signaling NaN returns quieted NaN
// - Square root: quieted NaN or default NaN
// - Max/min with any NaN return source two
// - NaN compare mask zeros, unordered and negated predicates ones
// - Precision conversion quiets signaling NaN
// - Flag compares report unordered on NaN
// - Invalid infinity/zero arithmetic returns default NaN
// - Bad integer conversion returns integer indefinite
// - Unmasked invalid leaves destination unmodified
// - Quiet NaN alone raises no invalid in arithmetic, square root or precision conversion
// - Ordered and signaling compares trap quiet NaN
// - Invalid detection ignores flush and DAZ modes
// - Truncating stack store raises no vector exception
// - Bit 6 is denormals-are-zero control
// - Bit 15 flushes tiny masked results
// - Per-element conditions ORed into shared flags
module simd_fp_exception_unit
   import simd_fp_exc_pkg::*;
#(
   parameter int ELEMS = 4
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   // Datapath operation
   input  wire logic         op_valid_i,
   input  wire logic [3:0]   op_code_i,
   input  wire logic         op_double_i,
   input  wire logic         op_scalar_i,
   input  wire logic [2:0]   cmp_pred_i,
   input  wire logic [127:0] src1_i,
   input  wire logic [127:0] src2_i,
   input  wire logic [127:0] dp_result_i,
   input  wire logic [19:0]  dp_flags_i,
   input  wire logic [2:0]   dp_cmp_flags_i,
   // Completion and faults
   output logic              done_o,
   output logic      [127:0] result_o,
   output logic              result_we_o,
   output logic      [2:0]   cmp_flags_o,
   output logic              cmp_flags_we_o,
   output logic              vector_fp_fault_o,
   output logic              invalid_opcode_fault_o,
   // Mode outputs to datapath
   output logic              daz_mode_o,
   output logic      [1:0]   rounding_mode_o
);

   localparam int LANE_BITS = 32;
   localparam int PAD_BITS  = 160;

   function automatic logic [4:0] fp_class(input logic [63:0] v, input logic dp);
      logic exp_max;
      logic exp_zero;
      logic frac_zero;
      logic qbit;
      logic sgn;
      if (dp) begin
         exp_max   = &v[62:52];
         exp_zero  = ~|v[62:52];
         frac_zero = ~|v[51:0];
         qbit      = v[51];
         sgn       = v[63];
      end else begin
         exp_max   = &v[30:23];
         exp_zero  = ~|v[30:23];
         frac_zero = ~|v[22:0];
         qbit      = v[22];
         sgn       = v[31];
      end
      // Denormals count as nonzero here whatever the DAZ mode says
      fp_class = {exp_max & ~frac_zero, exp_max & ~frac_zero & ~qbit,
                  exp_max & frac_zero, exp_zero & frac_zero, sgn};
   endfunction

   function automatic logic [63:0] quieten(input logic [63:0] v, input logic dp);
      quieten = v | (dp ? QUIET_BIT_DP : QUIET_BIT_SP);
   endfunction

   // Out of signed 32-bit range; the single exact -2^31 case is allowed
   function automatic logic cvt_out_of_range(input logic [63:0] v, input logic dp);
      if (dp) begin
         cvt_out_of_range = (v[62:52] > CVT_DP_EXP_LIMIT) ||
                            ((v[62:52] == CVT_DP_EXP_LIMIT) && !(v[63] && ~|v[51:0]));
      end else begin
         cvt_out_of_range = (v[30:23] > CVT_SP_EXP_LIMIT) ||
                            ((v[30:23] == CVT_SP_EXP_LIMIT) && !(v[31] && ~|v[22:0]));
      end
   endfunction

   logic [CSR_WIDTH-1:0]   csr_q;
   logic [CSR_WIDTH-1:0]   csr_d;
   logic                   os_fault_q;
   logic [NUM_CLASSES-1:0] last_exc_q;
   logic                   vec_seen_q;
   logic                   bad_op_seen_q;
   logic                   ack_q;
   logic [31:0]            rdata_q;
   logic                   done_q;
   logic [127:0]           result_q;
   logic                   result_we_q;
   logic [2:0]             cmp_flags_q;
   logic                   cmp_flags_we_q;
   logic                   vec_fault_q;
   logic                   bad_op_q;

   logic [PAD_BITS-1:0]    src1_x;
   logic [PAD_BITS-1:0]    src2_x;
   logic [PAD_BITS-1:0]    dp_x;
   logic [NUM_CLASSES*ELEMS-1:0] exc_flat;
   logic [ELEMS-1:0]       unord_flat;
   logic [64*ELEMS-1:0]    elem_res_flat;
   logic [127:0]           result_d;
   logic [NUM_CLASSES-1:0] new_exc;
   logic [NUM_CLASSES-1:0] unmasked;
   logic                   any_unmasked;
   logic                   fp_op;
   logic                   res_dp;
   op_e                    op;

   assign src1_x = {32'h0, src1_i};
   assign src2_x = {32'h0, src2_i};
   assign dp_x   = {32'h0, dp_result_i};
   assign op     = op_e'(op_code_i);
   assign fp_op  = (op != OP_INT) && (op != OP_STACK_TRUNC);
   assign res_dp = (op == OP_CVT_FP) ? ~op_double_i : op_double_i;

   // Per-element invalid detection and masked response
   for (genvar e = 0; e < ELEMS; e++) begin : g_elem
      localparam bit EVEN  = (e % 2) == 0;
      localparam bit SUB_DP = (e == 0);
      logic [63:0] a;
      logic [63:0] b;
      logic [63:0] d;
      logic [4:0]  c1;
      logic [4:0]  c2;
      logic        act;
      logic        inv;
      logic        ovr;
      logic        unord;
      logic        sub_eff;
      logic [63:0] val;
      logic [63:0] res;
      logic [4:0]  dpf;

      assign a   = op_double_i ? src1_x[LANE_BITS*e +: 64] : {32'h0, src1_x[LANE_BITS*e +: 32]};
      assign b   = op_double_i ? src2_x[LANE_BITS*e +: 64] : {32'h0, src2_x[LANE_BITS*e +: 32]};
      assign d   = res_dp ? dp_x[LANE_BITS*e +: 64] : {32'h0, dp_x[LANE_BITS*e +: 32]};
      assign c1  = fp_class(a, op_double_i);
      assign c2  = fp_class(b, op_double_i);
      assign dpf = dp_flags_i[5*e +: 5];
      assign act = op_scalar_i ? (e == 0) : (op_double_i ? EVEN : 1'b1);

      always_comb begin
         inv     = 1'b0;
         ovr     = 1'b0;
         unord   = 1'b0;
         val     = op_double_i ? DEFAULT_NAN_DP : {32'h0, DEFAULT_NAN_SP};
         sub_eff = c1[CL_SGN] ^ c2[CL_SGN] ^ ((op == OP_SUB) ||
                   ((op == OP_ADDSUB) && (op_double_i ? SUB_DP : EVEN)));
         case (op)
            OP_ADD, OP_SUB, OP_ADDSUB, OP_MUL, OP_DIV: begin
               if (c1[CL_SNAN] || c2[CL_SNAN]) begin
                  inv = 1'b1;
                  val = c1[CL_NAN] ? quieten(a, op_double_i) : quieten(b, op_double_i);
               end else if (!c1[CL_NAN] && !c2[CL_NAN]) begin
                  // Quiet NaN alone passes through the datapath result
                  case (op)
                     OP_MUL: inv = (c1[CL_INF] && c2[CL_ZERO]) ||
                                   (c1[CL_ZERO] && c2[CL_INF]);
                     OP_DIV: inv = (c1[CL_ZERO] && c2[CL_ZERO]) ||
                                   (c1[CL_INF] && c2[CL_INF]);
                     default: inv = c1[CL_INF] && c2[CL_INF] && sub_eff;
                  endcase
               end
               ovr = inv;
            end
            OP_SQRT: begin
               if (c1[CL_SNAN]) begin
                  inv = 1'b1;
                  val = quieten(a, op_double_i);
               end else begin
                  inv = c1[CL_SGN] && !c1[CL_ZERO] && !c1[CL_NAN];
               end
               ovr = inv;
            end
            OP_MAX, OP_MIN: begin
               inv = c1[CL_NAN] || c2[CL_NAN];
               ovr = inv;
               val = b;
            end
            OP_CMP_MASK: begin
               ovr = c1[CL_NAN] || c2[CL_NAN];
               inv = c1[CL_SNAN] || c2[CL_SNAN] || (ovr &&
                     ((cmp_pred_i == PRED_LT) || (cmp_pred_i == PRED_LE) ||
                      (cmp_pred_i == PRED_NLT) || (cmp_pred_i == PRED_NLE)));
               val = ((cmp_pred_i == PRED_NEQ) || (cmp_pred_i == PRED_UNORD) ||
                      (cmp_pred_i == PRED_NLT) || (cmp_pred_i == PRED_NLE)) ?
                     (op_double_i ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff) :
                     64'h0;
            end
            OP_CMP_ORD, OP_CMP_UNORD: begin
               unord = c1[CL_NAN] || c2[CL_NAN];
               inv   = (op == OP_CMP_ORD) ? unord : (c1[CL_SNAN] || c2[CL_SNAN]);
            end
            OP_CVT_FP: begin
               inv = c1[CL_SNAN];
               ovr = inv;
               val = quieten(d, res_dp);
            end
            OP_CVT_INT, OP_CVT_INT_TR: begin
               inv = c1[CL_NAN] || c1[CL_INF] || cvt_out_of_range(a, op_double_i);
               ovr = inv;
               val = {32'h0, INT_INDEFINITE};
            end
            default: begin
               inv = 1'b0;
            end
         endcase
      end

      // Flush-to-zero keeps the true sign of a tiny masked result
      always_comb begin
         res = d;
         if (act && ovr && csr_q[MASK_LSB + INVALID_OP_BIT]) begin
            res = val;
         end else if (act && fp_op && csr_q[FTZ_BIT] &&
                      csr_q[MASK_LSB + UNDERFLOW_BIT] && dpf[UNDERFLOW_BIT-1]) begin
            res = res_dp ? {d[63], 63'h0} : {32'h0, d[31], 31'h0};
         end
      end

      assign exc_flat[NUM_CLASSES*e +: NUM_CLASSES] =
         (act && fp_op) ? {dpf, inv} : '0;
      assign unord_flat[e] = act && unord;
      assign elem_res_flat[64*e +: 64] = res;

      if (EVEN) begin : g_lo
         assign result_d[LANE_BITS*e +: LANE_BITS] = res[31:0];
      end else begin : g_hi
         assign result_d[LANE_BITS*e +: LANE_BITS] =
            res_dp ? elem_res_flat[64*(e-1)+32 +: 32] : res[31:0];
      end
   end

   always_comb begin
      new_exc = '0;
      for (int i = 0; i < ELEMS; i++) begin
         new_exc = new_exc | exc_flat[NUM_CLASSES*i +: NUM_CLASSES];
      end
      if (!op_valid_i) begin
         new_exc = '0;
      end
   end

   assign unmasked     = new_exc & ~csr_q[MASK_LSB +: NUM_CLASSES];
   assign any_unmasked = |unmasked;

   // Wishbone slave, one wait state, ack drops after one cycle
   logic bus_req;
   logic bus_wr;
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign bus_wr  = bus_req && wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= bus_req;
         if (bus_req) begin
            if (wb_adr_i == CSR_OFFSET) begin
               rdata_q <= {16'h0, csr_q};
            end else if (wb_adr_i == OS_CTRL_OFFSET) begin
               rdata_q <= 32'(os_fault_q) << OS_FAULT_BIT;
            end else if (wb_adr_i == STATUS_OFFSET) begin
               rdata_q <= (32'(bad_op_seen_q) << STAT_BAD_OP_BIT) |
                          (32'(vec_seen_q) << STAT_VEC_FAULT_BIT) | 32'(last_exc_q);
            end else begin
               rdata_q <= 32'h0;
            end
         end
      end
   end

   // Control/status: bus write by byte lane, then hardware sets win over clears
   always_comb begin
      csr_d = csr_q;
      if (bus_wr && (wb_adr_i == CSR_OFFSET)) begin
         if (wb_sel_i[0]) begin
            csr_d[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            csr_d[15:8] = wb_dat_i[15:8];
         end
      end
      csr_d[FLAG_LSB +: NUM_CLASSES] = csr_d[FLAG_LSB +: NUM_CLASSES] | new_exc;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         csr_q <= CSR_RESET;
      end else begin
         csr_q <= csr_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         os_fault_q <= OS_CTRL_RESET;
      end else if (bus_wr && (wb_adr_i == OS_CTRL_OFFSET) && wb_sel_i[1]) begin
         os_fault_q <= wb_dat_i[OS_FAULT_BIT];
      end
   end

   // Completion: faults appear with done, never after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q         <= 1'b0;
         result_q       <= 128'h0;
         result_we_q    <= 1'b0;
         cmp_flags_q    <= 3'h0;
         cmp_flags_we_q <= 1'b0;
         vec_fault_q    <= 1'b0;
         bad_op_q       <= 1'b0;
      end else begin
         done_q         <= op_valid_i;
         result_q       <= result_d;
         result_we_q    <= op_valid_i && !any_unmasked && (op != OP_CMP_ORD) &&
                           (op != OP_CMP_UNORD) && (op != OP_STACK_TRUNC);
         cmp_flags_q    <= (unord_flat[0]) ? UNORDERED_FLAGS : dp_cmp_flags_i;
         cmp_flags_we_q <= op_valid_i && !any_unmasked &&
                           ((op == OP_CMP_ORD) || (op == OP_CMP_UNORD));
         vec_fault_q    <= any_unmasked && os_fault_q;
         bad_op_q       <= any_unmasked && !os_fault_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_exc_q    <= '0;
         vec_seen_q    <= 1'b0;
         bad_op_seen_q <= 1'b0;
      end else if (any_unmasked) begin
         last_exc_q    <= unmasked;
         vec_seen_q    <= os_fault_q;
         bad_op_seen_q <= !os_fault_q;
      end
   end

   assign wb_ack_o               = ack_q;
   assign wb_dat_o               = rdata_q;
   assign done_o                 = done_q;
   assign result_o               = result_q;
   assign result_we_o            = result_we_q;
   assign cmp_flags_o            = cmp_flags_q;
   assign cmp_flags_we_o         = cmp_flags_we_q;
   assign vector_fp_fault_o      = vec_fault_q;
   assign invalid_opcode_fault_o = bad_op_q;
   assign daz_mode_o             = csr_q[DAZ_BIT];
   assign rounding_mode_o        = csr_q[RC_LSB +: 2];

endmodule

// File: simd_fp_exception_unit_test.sv
`timescale 1ns/1ps

module simd_fp_exception_unit_test;
   import simd_fp_exc_pkg::*;
   localparam logic [31:0] ONE = 32'h3f80_0000;
   localparam logic [31:0] SNAN = 32'h7fa0_0000;
   localparam logic [31:0] QNAN = 32'h7fc0_0000;
   localparam logic [63:0] D_ONE = 64'h3ff0_0000_0000_0000;
   localparam logic [63:0] D_SNAN = 64'h7ff4_0000_0000_0000;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, op_valid_i, op_scalar_i;
   logic done_o, result_we_o, cmp_flags_we_o, vector_fp_fault_o, invalid_opcode_fault_o;
   logic daz_mode_o, op_double_i;
   logic [1:0] rounding_mode_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, op_code_i;
   logic [2:0] cmp_pred_i, dp_cmp_flags, cmp_flags_o;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [127:0] src1_i, src2_i, dp_result, result_o;
   logic [19:0] dp_flags, flag_req;
   int num_errors, total_checks;
   // Scalar special-value table: op, source one, source two, expected lane 0
   logic [3:0] tc[8] = '{OP_SQRT, OP_SQRT, OP_MUL, OP_ADD, OP_SUB, OP_DIV, OP_CVT_INT,
                         OP_CVT_INT_TR};
   logic [31:0] ta[8] = '{32'hbf80_0000, SNAN, 32'h7f80_0000, 32'h7f80_0000,
                          32'h7f80_0000, 32'h0, QNAN, 32'h7f80_0000};
   logic [31:0] tb[8] = '{32'h0, 32'h0, 32'h0, 32'hff80_0000, 32'h7f80_0000, 32'h0, 32'h0,
                          32'h0};
   logic [31:0] te[8] = '{32'hffc0_0000, 32'h7fe0_0000, 32'hffc0_0000, 32'hffc0_0000,
                          32'hffc0_0000, 32'hffc0_0000, 32'h8000_0000, 32'h8000_0000};

   simd_fp_exception_unit i_simd_fp_exception_unit (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i),
      .op_code_i(op_code_i), .op_double_i(op_double_i), .op_scalar_i(op_scalar_i),
      .cmp_pred_i(cmp_pred_i), .src1_i(src1_i), .src2_i(src2_i), .dp_result_i(dp_result),
      .dp_flags_i(dp_flags), .dp_cmp_flags_i(dp_cmp_flags), .done_o(done_o),
      .result_o(result_o), .result_we_o(result_we_o), .cmp_flags_o(cmp_flags_o),
      .cmp_flags_we_o(cmp_flags_we_o), .vector_fp_fault_o(vector_fp_fault_o),
      .invalid_opcode_fault_o(invalid_opcode_fault_o), .daz_mode_o(daz_mode_o),
      .rounding_mode_o(rounding_mode_o));

   simd_fp_datapath_model i_simd_fp_datapath_model (
      .op_valid_i(op_valid_i), .src1_i(src1_i), .src2_i(src2_i), .flag_req_i(flag_req),
      .dp_result_o(dp_result), .dp_flags_o(dp_flags), .dp_cmp_flags_o(dp_cmp_flags));

   task automatic end_of_test;
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; ack and data are taken at the edge after the one that raises them
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'h3;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk_word(rd, exp);
   endtask

   task automatic op(input logic [3:0] code, input logic [2:0] pred, input logic scl,
                     input logic [127:0] a, input logic [127:0] b, input logic [19:0] fl);
      op_valid_i <= 1'b1;
      op_code_i <= code;
      cmp_pred_i <= pred;
      op_scalar_i <= scl;
      src1_i <= a;
      src2_i <= b;
      flag_req <= fl;
      @(posedge clk_i);
      op_valid_i <= 1'b0;
      @(posedge clk_i);
      chk_word({31'h0, done_o}, 32'h1);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, op_valid_i, op_scalar_i, op_double_i} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, op_code_i, cmp_pred_i, flag_req} = '0;
      {src1_i, src2_i} = '0;
      num_errors = 0;
      total_checks = 0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(CSR_OFFSET, 32'h1f80);
      rchk(OS_CTRL_OFFSET, 32'h0);
      rchk(STATUS_OFFSET, 32'h0);
      rchk(8'h0c, 32'h0);
      // Flush and denormal modes on while invalid is detected
      wb(1'b1, CSR_OFFSET, 32'hffc0);
      chk_word({29'h0, daz_mode_o, rounding_mode_o}, 32'h7);
      // Lane 2 underflows on a nonzero datapath value, so only a flush gives zero
      op(OP_ADD, PRED_EQ, 1'b0, {ONE, 32'h0080_0000, ONE, SNAN}, {4{ONE}}, 20'h02000);
      chk_vec(result_o, {96'h0, 32'h7fe0_0000});
      rchk(CSR_OFFSET, 32'hffd1);
      op_double_i <= 1'b1;
      op(OP_ADD, PRED_EQ, 1'b0, {D_ONE, D_SNAN}, {2{D_ONE}}, 20'h0);
      chk_vec(result_o, {64'h0, 64'h7ffc_0000_0000_0000});
      op(OP_CVT_FP, PRED_EQ, 1'b1, {64'h0, D_SNAN}, {96'h0, SNAN}, 20'h0);
      chk_word(result_o[31:0], 32'h7fe0_0000);
      op_double_i <= 1'b0;
      wb(1'b1, CSR_OFFSET, 32'h1f80);
      op(OP_ADD, PRED_EQ, 1'b0, {{3{ONE}}, QNAN}, {4{ONE}}, 20'h0);
      rchk(CSR_OFFSET, 32'h1f80);
      op(OP_MAX, PRED_EQ, 1'b0, {{3{32'h4000_0000}}, QNAN}, {4{ONE}}, 20'h0);
      chk_vec(result_o, {{3{32'h7f80_0000}}, ONE});
      op(OP_INT, PRED_EQ, 1'b0, {4{SNAN}}, {4{ONE}}, 20'h0);
      rchk(CSR_OFFSET, 32'h1f81);
      for (int i = 0; i < 8; i++) begin
         op(tc[i], PRED_EQ, 1'b1, {96'h0, ta[i]}, {96'h0, tb[i]}, 20'h0);
         chk_word(result_o[31:0], te[i]);
      end
      for (int p = 0; p < 8; p++) begin
         wb(1'b1, CSR_OFFSET, 32'h1f80);
         op(OP_CMP_MASK, p[2:0], 1'b0, {{3{ONE}}, QNAN}, {4{ONE}}, 20'h0);
         chk_word(result_o[31:0], (p inside {3, 4, 5, 6}) ? 32'hffff_ffff : 32'h0);
         rchk(CSR_OFFSET, (p inside {1, 2, 5, 6}) ? 32'h1f81 : 32'h1f80);
      end
      op(OP_CMP_ORD, PRED_EQ, 1'b1, {96'h0, QNAN}, {96'h0, ONE}, 20'h0);
      chk_word({28'h0, cmp_flags_we_o, cmp_flags_o}, {28'h0, 1'b1, UNORDERED_FLAGS});
      rchk(CSR_OFFSET, 32'h1f81);
      // Invalid unmasked: fault kind follows the OS support bit
      wb(1'b1, CSR_OFFSET, 32'h1f00);
      rchk(CSR_OFFSET, 32'h1f00);
      op(OP_ADD, PRED_EQ, 1'b0, {{3{ONE}}, SNAN}, {4{ONE}}, 20'h0);
      chk_word({29'h0, vector_fp_fault_o, invalid_opcode_fault_o, result_we_o}, 32'h2);
      rchk(STATUS_OFFSET, 32'h201);
      wb(1'b1, OS_CTRL_OFFSET, 32'h400);
      rchk(OS_CTRL_OFFSET, 32'h400);
      op(OP_ADD, PRED_EQ, 1'b0, {{3{ONE}}, SNAN}, {4{ONE}}, 20'h0);
      chk_word({29'h0, vector_fp_fault_o, invalid_opcode_fault_o, result_we_o}, 32'h4);
      rchk(STATUS_OFFSET, 32'h101);
      op(OP_INT, PRED_EQ, 1'b0, {4{SNAN}}, {4{ONE}}, 20'h0);
      chk_word({29'h0, vector_fp_fault_o, invalid_opcode_fault_o, result_we_o}, 32'h1);
      op(OP_STACK_TRUNC, PRED_EQ, 1'b1, {4{SNAN}}, {4{ONE}}, 20'h0);
      chk_word({29'h0, vector_fp_fault_o, invalid_opcode_fault_o, result_we_o}, 32'h0);
      end_of_test();
   end
endmodule
